// ---- design/spr_baud.sv ----
`timescale 1ns/10ps
`default_nettype none

`include "spr_defines.svh"

module spr_baud
(
  // Clock and reset.
  input wire logic clk,
  input wire logic rstn,
  // Control.
  input wire logic run,
  input wire logic [1:0] rate,
  // One pulse per half serial clock period.
  output logic tick
);

  spr_pkg::spr_baud_type s;
  spr_pkg::spr_baud_type next_s;

  function automatic logic [6:0] limit(input logic [1:0] r);
    case (r)
      2'h0: limit = `SPR_BD_0;
      2'h1: limit = `SPR_BD_1;
      2'h2: limit = `SPR_BD_2;
      default: limit = `SPR_BD_3;
    endcase
  endfunction : limit

  // A half period lasts the divisor in base clocks.
  assign tick = run && (s.cnt == limit(rate));

  always_comb
  begin
    next_s = s;
    if (!run || tick)
    begin
      next_s.cnt = 7'h00;
    end
    else
    begin
      next_s.cnt = s.cnt + 7'h01;
    end
  end

  always_ff @(posedge clk)
  begin
    if (!rstn)
    begin
      s <= '0;
    end
    else
    begin
      s <= next_s;
    end
  end

endmodule : spr_baud

`default_nettype wire

// ---- design/spr_defines.svh ----
`ifndef SPR_DEFINES_SVH
`define SPR_DEFINES_SVH

// Register offsets on the local port.
`define SPR_OFS_CTRL 2'h0
`define SPR_OFS_STAT 2'h1
`define SPR_OFS_DATA 2'h2

// Control register fields.
`define SPR_C_RIE 7
`define SPR_C_DMA 6
`define SPR_C_MSTR 5
`define SPR_C_CLOCK_PHASE_SEL 3
`define SPR_C_WOM 2
`define SPR_C_EN 1
`define SPR_C_TIE 0
`define SPR_CTRL_RST 8'h28

// Status and control register fields.
`define SPR_S_RF 7
`define SPR_S_EIE 6
`define SPR_S_OVR 5
`define SPR_S_MF 4
`define SPR_S_TE 3
`define SPR_S_MFE 2
`define SPR_S_RHI 1
`define SPR_S_RLO 0

// Rate divisors, stored as divisor minus one.
`define SPR_BD_0 7'h01
`define SPR_BD_1 7'h07
`define SPR_BD_2 7'h1F
`define SPR_BD_3 7'h7F

// Sixteen clock edges make one byte.
`define SPR_LAST_EDGE 4'hF
`define SPR_BYTE_ZERO 8'h00

`endif

// ---- design/spr_pkg.sv ----
package spr_pkg;

  typedef enum logic {spr_idle, spr_xfer} spr_state_type;

  typedef struct packed {
    logic [3:0] meta;
    logic [3:0] sync;
  } spr_sync_type;

  typedef struct packed {
    logic [6:0] cnt;
  } spr_baud_type;

  typedef struct packed {
    spr_state_type state;
    logic [7:0] ctrl;
    logic err_ie;
    logic mfe;
    logic [1:0] rate;
    logic rx_full;
    logic ovr;
    logic mf;
    logic tx_full;
    logic rf_arm;
    logic ov_arm;
    logic mf_arm;
    logic [7:0] tx_buf;
    logic [7:0] sh;
    logic [7:0] rxs;
    logic [7:0] rx_buf;
    logic sh_loaded;
    logic [3:0] edge_cnt;
    logic sck;
    logic sck_d;
    logic ss_d;
    logic [7:0] rdata;
  } spr_core_type;

endpackage : spr_pkg

// ---- design/spr_sync.sv ----
`timescale 1ns/10ps
`default_nettype none

module spr_sync
(
  // Clock and reset.
  input wire logic clk,
  input wire logic rstn,
  // Pin levels.
  input wire logic [3:0] pin_in,
  output logic [3:0] pin_out
);

  spr_pkg::spr_sync_type s;
  spr_pkg::spr_sync_type next_s;

  always_comb
  begin
    next_s = s;
    next_s.meta = pin_in;
    next_s.sync = s.meta;
  end

  // Each pin gets its own two-stage chain; reset parks them high.
  always_ff @(posedge clk)
  begin
    if (!rstn)
    begin
      s <= '1;
    end
    else
    begin
      s <= next_s;
    end
  end

  assign pin_out = s.sync;

endmodule : spr_sync

`default_nettype wire

// ---- design/spr_top.sv ----
// Functional notes
// - Phase bit picks timing, resets to one.
// - Phase-zero slave starts on select fall.
// - Started slave takes no new shift byte.
// - Phase-one slave starts on first clock edge.
// - Deselected slave floats output, ignores clocks.
// - Wired-or bit makes outputs open drain.
// - Enable clear partially resets; reset clears it.
// - Transmit enable gates empty-flag request.
// - Receive full sets on byte arrival.
// - Receive full clear sequence depends on routing.
// - Error enable gates overrun and fault interrupt.
// - Overrun keeps old byte, status-then-data clears.
// - Mode fault from select on slave/master.
// - Fault clears by status read, data write.
// - Empty flag sets on buffer hand-over.
// - Data write clears empty flag.
// - Idle port passes written byte straight through.
// - Busy slave defers shift register load.
// - Fault enable low frees select on master.
// - Rate field divides base clock, master only.
// - Data writes fill transmit, reads return receive.
// - Routing bit steers receive and transmit requests to DMA.
// - One byte per eight serial clocks.
// - Slave when master bit low, select low.
`timescale 1ns/10ps
`default_nettype none

`include "spr_defines.svh"

module spr_top
(
  // Clock and reset.
  input wire logic clk,
  input wire logic rstn,
  // Register port.
  input wire logic [1:0] addr,
  input wire logic [7:0] wdata,
  input wire logic wr_en,
  input wire logic rd_en,
  output logic [7:0] rdata,
  // Service requests.
  output logic cpu_irq,
  output logic dma_rx_req,
  output logic dma_tx_req,
  // Serial clock pin.
  input wire logic serial_clk_pin_in,
  output logic serial_clk_pin_out,
  output logic serial_clk_pin_oe_n,
  // Master out pin.
  input wire logic mosi_in,
  output logic mosi_out,
  output logic mosi_oe_n,
  // Master in pin.
  input wire logic miso_in,
  output logic miso_out,
  output logic miso_oe_n,
  // Slave select pin.
  input wire logic slave_select_n
);

  spr_pkg::spr_core_type s;
  spr_pkg::spr_core_type next_s;

  logic [3:0] pins;
  logic sck_s;
  logic mosi_s;
  logic miso_s;
  logic ss_s;
  logic tick;
  logic en;
  logic mstr;
  logic clock_phase_sel;
  logic dma;
  logic mstr_on;
  logic slave_sel;
  logic busy;
  logic stat_rd;
  logic data_rd;
  logic data_wr;
  logic ev;
  logic lead;
  logic samp;
  logic shft;
  logic din;
  logic done;
  logic start;
  logic rf_clr;
  logic [7:0] stat_val;
  logic [7:0] rx_byte;
  logic te;

  function automatic logic hit(input logic [1:0] a,
                               input logic [1:0] ofs);
    hit = (a == ofs);
  endfunction : hit

  // Returns {level, enable_n} for a pin that may be open drain.
  function automatic logic [1:0] drv(input logic on, input logic v,
                                     input logic wom);
    if (wom)
    begin
      drv = {1'b0, ~(on & ~v)};
    end
    else
    begin
      drv = {v, ~on};
    end
  endfunction : drv

  spr_sync u_sync
  (
    .clk(clk),
    .rstn(rstn),
    .pin_in({serial_clk_pin_in, mosi_in, miso_in, slave_select_n}),
    .pin_out(pins)
  );

  assign sck_s = pins[3];
  assign mosi_s = pins[2];
  assign miso_s = pins[1];
  assign ss_s = pins[0];

  assign en = s.ctrl[`SPR_C_EN];
  assign mstr = s.ctrl[`SPR_C_MSTR];
  assign clock_phase_sel = s.ctrl[`SPR_C_CLOCK_PHASE_SEL];
  assign dma = s.ctrl[`SPR_C_DMA];
  assign busy = (s.state == spr_pkg::spr_xfer);
  assign mstr_on = en & mstr;
  assign slave_sel = en & ~mstr & ~ss_s;
  assign te = ~s.tx_full;

  spr_baud u_baud
  (
    .clk(clk),
    .rstn(rstn),
    .run(mstr_on & busy),
    .rate(s.rate),
    .tick(tick)
  );

  always_comb
  begin
    next_s = s;
    stat_rd = rd_en && hit(addr, `SPR_OFS_STAT);
    data_rd = rd_en && hit(addr, `SPR_OFS_DATA);
    data_wr = wr_en && hit(addr, `SPR_OFS_DATA);
    stat_val = `SPR_BYTE_ZERO;
    stat_val[`SPR_S_RF] = s.rx_full;
    stat_val[`SPR_S_EIE] = s.err_ie;
    stat_val[`SPR_S_OVR] = s.ovr;
    stat_val[`SPR_S_MF] = s.mf;
    stat_val[`SPR_S_TE] = te;
    stat_val[`SPR_S_MFE] = s.mfe;
    stat_val[`SPR_S_RHI] = s.rate[1];
    stat_val[`SPR_S_RLO] = s.rate[0];
    // Clock edges: the master uses its divider, a selected slave the pin.
    ev = 1'b0;
    if (mstr_on && busy)
    begin
      ev = tick;
    end
    else if (slave_sel && busy)
    begin
      ev = sck_s ^ s.sck_d;
    end
    lead = ~s.edge_cnt[0];
    samp = clock_phase_sel ? ~lead : lead;
    shft = clock_phase_sel ? (lead && (s.edge_cnt != 4'h0)) : ~lead;
    din = mstr ? miso_s : mosi_s;
    rx_byte = samp ? {s.rxs[6:0], din} : s.rxs;
    done = ev && (s.edge_cnt == `SPR_LAST_EDGE);
    start = 1'b0;
    rf_clr = 1'b0;
    next_s.sck_d = sck_s;
    next_s.ss_d = ss_s;
    next_s.rdata = `SPR_BYTE_ZERO;

    // Read data stand one cycle after the strobe.
    if (rd_en)
    begin
      case (addr)
        `SPR_OFS_CTRL: next_s.rdata = s.ctrl;
        `SPR_OFS_STAT: next_s.rdata = stat_val;
        `SPR_OFS_DATA: next_s.rdata = s.rx_buf;
        default: next_s.rdata = `SPR_BYTE_ZERO;
      endcase
    end

    // Register writes.
    if (wr_en && hit(addr, `SPR_OFS_CTRL))
    begin
      next_s.ctrl = wdata;
    end
    if (wr_en && hit(addr, `SPR_OFS_STAT))
    begin
      next_s.err_ie = wdata[`SPR_S_EIE];
      next_s.mfe = wdata[`SPR_S_MFE];
      next_s.rate = {wdata[`SPR_S_RHI], wdata[`SPR_S_RLO]};
    end

    // First step of the two-step clears.
    if (stat_rd)
    begin
      next_s.rf_arm = s.rx_full;
      next_s.ov_arm = s.ovr;
      next_s.mf_arm = s.mf;
    end

    // Second step; flags seen by a status read clear on the data access.
    if (data_rd)
    begin
      rf_clr = s.rf_arm | dma;
      if (rf_clr)
      begin
        next_s.rx_full = 1'b0;
      end
      if (s.ov_arm)
      begin
        next_s.ovr = 1'b0;
      end
      next_s.rf_arm = 1'b0;
      next_s.ov_arm = 1'b0;
    end
    if (data_wr && s.mf_arm)
    begin
      next_s.mf = 1'b0;
      next_s.mf_arm = 1'b0;
    end

    // Shifting. Sample and shift sit on opposite edges of each clock.
    if (ev)
    begin
      next_s.edge_cnt = s.edge_cnt + 4'h1;
      if (mstr_on)
      begin
        next_s.sck = ~s.sck;
      end
      if (samp)
      begin
        next_s.rxs = {s.rxs[6:0], din};
      end
      if (shft)
      begin
        next_s.sh = {s.sh[6:0], 1'b0};
      end
    end

    // Completion moves the byte on unless the old one is still unread.
    if (done)
    begin
      next_s.state = spr_pkg::spr_idle;
      next_s.sck = 1'b0;
      if (s.rx_full && !rf_clr)
      begin
        next_s.ovr = 1'b1;
      end
      else
      begin
        next_s.rx_buf = rx_byte;
        next_s.rx_full = 1'b1;
      end
    end

    // Start of a byte.
    if (!busy && mstr_on && s.sh_loaded)
    begin
      start = 1'b1;
      next_s.edge_cnt = 4'h0;
    end
    else if (!busy && slave_sel && !clock_phase_sel && !ss_s && s.ss_d)
    begin
      start = 1'b1;
      next_s.edge_cnt = 4'h0;
    end
    else if (!busy && slave_sel && clock_phase_sel && (sck_s ^ s.sck_d))
    begin
      start = 1'b1;
      next_s.edge_cnt = 4'h1;
    end
    if (start)
    begin
      next_s.state = spr_pkg::spr_xfer;
      next_s.sh_loaded = 1'b0;
      next_s.sck = 1'b0;
    end

    // Hand-over only while idle, so a busy slave keeps the buffer.
    if (en && !busy && !start && s.tx_full && !s.sh_loaded)
    begin
      next_s.sh = s.tx_buf;
      next_s.sh_loaded = 1'b1;
      next_s.tx_full = 1'b0;
    end
    if (data_wr)
    begin
      next_s.tx_buf = wdata;
      next_s.tx_full = 1'b1;
    end

    // Select level checks. With the enable low the pin is left alone.
    if (s.mfe && mstr_on && !ss_s)
    begin
      next_s.mf = 1'b1;
      next_s.state = spr_pkg::spr_idle;
      next_s.sck = 1'b0;
    end
    if (s.mfe && en && !mstr && busy && ss_s && !s.ss_d)
    begin
      next_s.mf = 1'b1;
    end

    // Disabling drops the transfer and buffers but keeps the setup.
    if (!en)
    begin
      next_s.state = spr_pkg::spr_idle;
      next_s.sh_loaded = 1'b0;
      next_s.tx_full = 1'b0;
      next_s.rx_full = 1'b0;
      next_s.ovr = 1'b0;
      next_s.sck = 1'b0;
      next_s.edge_cnt = 4'h0;
    end
  end

  always_ff @(posedge clk)
  begin
    if (!rstn)
    begin
      s <= '0;
      s.ctrl <= `SPR_CTRL_RST;
      s.sck_d <= 1'b1;
      s.ss_d <= 1'b1;
    end
    else
    begin
      s <= next_s;
    end
  end

  assign rdata = s.rdata;

  // Requests go either to the processor or to the DMA engine.
  assign cpu_irq = (~dma & s.ctrl[`SPR_C_RIE] & s.rx_full)
    | (~dma & s.ctrl[`SPR_C_TIE] & te)
    | (s.err_ie & (s.ovr | s.mf));
  assign dma_rx_req = dma & s.ctrl[`SPR_C_RIE] & s.rx_full;
  assign dma_tx_req = dma & s.ctrl[`SPR_C_TIE] & te;

  // The wired-or choice applies to all three driven pins.
  assign {serial_clk_pin_out, serial_clk_pin_oe_n} =
    drv(mstr_on, s.sck, s.ctrl[`SPR_C_WOM]);
  assign {mosi_out, mosi_oe_n} =
    drv(mstr_on, s.sh[7], s.ctrl[`SPR_C_WOM]);
  assign {miso_out, miso_oe_n} =
    drv(slave_sel, s.sh[7], s.ctrl[`SPR_C_WOM]);

endmodule : spr_top

`default_nettype wire

// ---- sim/spr_slave_model.sv ----
`timescale 1ns/10ps
`default_nettype none

module spr_slave_model
(
  // Link pins.
  input wire logic sck,
  input wire logic mosi,
  input wire logic sel_n,
  output logic miso,
  // Byte side.
  input wire logic [7:0] tx,
  output logic [7:0] rx,
  output int done
);
  logic [7:0] sh;
  logic [7:0] acc;
  int n;
  initial
  begin
    miso = 1'b0;
    sh = 8'h00;
    acc = 8'h00;
    rx = 8'h00;
    n = 0;
    done = 0;
  end
  // A released line flips, so a stale bit can never pass for data.
  always @(posedge sel_n)
    miso <= ~miso;
  // Leading edge loads or shifts the next bit out.
  always @(posedge sck)
  begin
    if (!sel_n)
    begin
      sh = (n == 0) ? tx : {sh[6:0], 1'b0};
      miso <= sh[7];
    end
  end
  // Trailing edge samples, eight bits make a byte.
  always @(negedge sck)
  begin
    if (!sel_n)
    begin
      acc = {acc[6:0], mosi};
      n = n + 1;
      if (n == 8)
      begin
        rx = acc;
        n = 0;
        done = done + 1;
      end
    end
  end
endmodule : spr_slave_model

`default_nettype wire

// ---- sim/spr_top_properties.sv ----
`timescale 1ns/10ps
`default_nettype none

module spr_top_properties
(
  // Clock and reset.
  input wire logic clk,
  input wire logic rstn,
  // Register port.
  input wire logic [1:0] addr,
  input wire logic rd_en,
  input wire logic [7:0] rdata,
  // Requests.
  input wire logic cpu_irq,
  input wire logic dma_rx_req,
  input wire logic dma_tx_req,
  // Pins.
  input wire logic serial_clk_pin_out,
  input wire logic serial_clk_pin_oe_n,
  input wire logic mosi_oe_n,
  input wire logic miso_oe_n,
  input wire logic slave_select_n
);
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!rstn);
  sequence s_rd_gap;
    rd_en && addr == 2'h3;
  endsequence
  sequence s_ss_high;
    slave_select_n [*6];
  endsequence
  property p_rd_idle;
    !rd_en |=> rdata == 8'h00;
  endproperty
  a_rd_idle: assert property (p_rd_idle) else $error("rdata not idle");
  property p_rd_gap;
    s_rd_gap |=> rdata == 8'h00;
  endproperty
  a_rd_gap: assert property (p_rd_gap) else $error("unmapped data");
  property p_rst_pins;
    $rose(rstn) |-> miso_oe_n && mosi_oe_n && serial_clk_pin_oe_n;
  endproperty
  a_rst_pins: assert property (p_rst_pins) else $error("pin driven");
  property p_rst_req;
    $rose(rstn) |-> !cpu_irq && !dma_rx_req && !dma_tx_req;
  endproperty
  a_rst_req: assert property (p_rst_req) else $error("request set");
  property p_rst_rdata;
    $rose(rstn) |-> rdata == 8'h00;
  endproperty
  a_rst_rdata: assert property (p_rst_rdata) else $error("rdata set");
  // Select is synchronised, so the release is given six cycles.
  property p_miso_ss;
    s_ss_high |-> miso_oe_n;
  endproperty
  a_miso_ss: assert property (p_miso_ss) else $error("miso driven");
  property p_excl;
    !miso_oe_n |-> serial_clk_pin_oe_n && mosi_oe_n;
  endproperty
  a_excl: assert property (p_excl) else $error("both roles");
  property p_sck_hold;
    $changed(serial_clk_pin_out) |=> $stable(serial_clk_pin_out);
  endproperty
  a_sck_hold: assert property (p_sck_hold) else $error("short half");
endmodule : spr_top_properties

`default_nettype wire

// ---- sim/spr_top_tb_top.sv ----
`timescale 1ns/10ps
`default_nettype none

`define CHK(a, b) \
  begin \
    check_count++; \
    if ((a) !== (b)) \
    begin \
      fail_count++; \
      $display("FAIL at %0t got %h expected %h", $time, a, b); \
    end \
  end

bind spr_top spr_top_properties u_prop (.clk, .rstn, .addr, .rd_en,
  .rdata, .cpu_irq, .dma_rx_req, .dma_tx_req, .serial_clk_pin_out,
  .serial_clk_pin_oe_n, .mosi_oe_n, .miso_oe_n, .slave_select_n);

module spr_top_tb_top;
  logic clk, rstn, wr_en, rd_en, rv, ss_n, msel_n, tb_sck, tb_mosi;
  logic [1:0] addr;
  logic [7:0] wdata, rdata, mtx, mrx, t, m, b1, got, qv;
  logic cpu_irq, dma_rx_req, dma_tx_req, m_miso;
  logic sck_out, sck_oe_n, mosi_out, mosi_oe_n, miso_out, miso_oe_n;
  logic sck_w, mosi_w, miso_w;
  logic [7:0] exp_q[$];
  int fail_count, check_count, cyc, seed, mdone;
  assign sck_w = sck_oe_n ? tb_sck : sck_out;
  assign mosi_w = mosi_oe_n ? tb_mosi : mosi_out;
  assign miso_w = miso_oe_n ? m_miso : miso_out;
  spr_top u_dut (.clk(clk), .rstn(rstn), .addr(addr), .wdata(wdata),
    .wr_en(wr_en), .rd_en(rd_en), .rdata(rdata), .cpu_irq(cpu_irq),
    .dma_rx_req(dma_rx_req), .dma_tx_req(dma_tx_req),
    .serial_clk_pin_in(sck_w), .serial_clk_pin_out(sck_out),
    .serial_clk_pin_oe_n(sck_oe_n), .mosi_in(mosi_w), .mosi_out(mosi_out),
    .mosi_oe_n(mosi_oe_n), .miso_in(miso_w), .miso_out(miso_out),
    .miso_oe_n(miso_oe_n), .slave_select_n(ss_n));
  spr_slave_model u_model (.sck(sck_w), .mosi(mosi_w), .sel_n(msel_n),
    .miso(m_miso), .tx(mtx), .rx(mrx), .done(mdone));
  initial
  begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end
  task complete_run;
    $display("checks %0d mismatches %0d", check_count, fail_count);
    if (fail_count == 0 && check_count > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask : complete_run
  always @(posedge clk)
  begin
    if (rv)
    begin
      qv = exp_q.pop_front();
      `CHK(rdata, qv)
    end
    rv <= rd_en;
    cyc++;
    if (cyc == 20000)
    begin
      fail_count++;
      complete_run();
    end
  end
  task wr(input logic [1:0] a, input logic [7:0] d);
    @(posedge clk);
    addr <= a;
    wdata <= d;
    wr_en <= 1'b1;
    @(posedge clk);
    wr_en <= 1'b0;
  endtask : wr
  task rd(input logic [1:0] a, input logic [7:0] e);
    @(posedge clk);
    addr <= a;
    rd_en <= 1'b1;
    exp_q.push_back(e);
    @(posedge clk);
    rd_en <= 1'b0;
  endtask : rd
  task xfer(input logic [7:0] d, input logic [7:0] mb, input logic [7:0] s);
    int k, n0;
    n0 = mdone;
    mtx = mb;
    wr(2'h2, d);
    rd(2'h1, s);
    for (k = 0; k < 3000 && mdone == n0; k++)
      @(posedge clk);
    `CHK(mrx, d)
    repeat (6) @(posedge clk);
    @(negedge clk);
  endtask : xfer
  // Data move in the middle of the low half, so either phase samples a
  // settled bit after the pin synchronisers.
  task sxfer(input logic [7:0] mb, output logic [7:0] so);
    int i;
    ss_n <= 1'b0;
    repeat (25) @(posedge clk);
    for (i = 7; i >= 0; i--)
    begin
      tb_mosi <= mb[i];
      repeat (5) @(posedge clk);
      tb_sck <= 1'b1;
      repeat (10) @(posedge clk);
      so[i] = miso_w;
      tb_sck <= 1'b0;
      repeat (5) @(posedge clk);
    end
    repeat (25) @(posedge clk);
    ss_n <= 1'b1;
  endtask : sxfer
  initial
  begin
    seed = 32'hcf1c;
    {rstn, wr_en, rd_en, rv, tb_sck, tb_mosi} = 6'h00;
    {ss_n, msel_n} = 2'h3;
    {addr, wdata, mtx} = 18'h00000;
    {fail_count, check_count, cyc} = 0;
    repeat (5) @(posedge clk);
    rstn <= 1'b1;
    rd(2'h0, 8'h28);
    rd(2'h1, 8'h08);
    rd(2'h2, 8'h00);
    t = 8'($random(seed));
    wr(2'h1, t);
    rd(2'h1, (t & 8'h47) | 8'h08);
    wr(2'h0, t & 8'hFD);
    rd(2'h0, t & 8'hFD);
    wr(2'h3, 8'hFF);
    rd(2'h3, 8'h00);
    $display("test registers done");
    msel_n <= 1'b0;
    wr(2'h1, 8'h01);
    wr(2'h0, 8'hAA);
    b1 = 8'($random(seed));
    xfer(t, b1, 8'h09);
    `CHK(cpu_irq, 1'b1)
    xfer(~t, ~b1, 8'h89);
    rd(2'h1, 8'hA9);
    rd(2'h2, b1);
    rd(2'h1, 8'h09);
    $display("test master done");
    wr(2'h0, 8'hEB);
    m = 8'($random(seed));
    xfer(t, m, 8'h09);
    `CHK(dma_rx_req, 1'b1)
    `CHK(dma_tx_req, 1'b1)
    `CHK(cpu_irq, 1'b0)
    rd(2'h2, m);
    @(negedge clk);
    `CHK(dma_rx_req, 1'b0)
    $display("test dma done");
    msel_n <= 1'b1;
    wr(2'h0, 8'h0A);
    t = 8'($random(seed));
    m = 8'($random(seed));
    wr(2'h2, t);
    sxfer(m, got);
    `CHK(got, t)
    rd(2'h1, 8'h89);
    rd(2'h2, m);
    $display("test slave done");
    wr(2'h0, 8'h02);
    wr(2'h2, ~t);
    sxfer(~m, got);
    `CHK(got, ~t)
    rd(2'h1, 8'h89);
    rd(2'h2, ~m);
    $display("test slave phase zero done");
    wr(2'h0, 8'h2E);
    wr(2'h1, 8'h45);
    ss_n <= 1'b0;
    repeat (5) @(posedge clk);
    @(negedge clk);
    `CHK(cpu_irq, 1'b1)
    wr(2'h1, 8'h41);
    ss_n <= 1'b1;
    rd(2'h1, 8'h59);
    wr(2'h2, t);
    rd(2'h1, 8'h49);
    @(negedge clk);
    `CHK(mosi_oe_n, t[7])
    `CHK(mosi_out, 1'b0)
    $display("test fault done");
    repeat (4) @(posedge clk);
    complete_run();
  end
endmodule : spr_top_tb_top

`default_nettype wire
